// file: core/rail_mode_pkg.sv
// rail_mode_pkg: register map, field layout, reset values and drive types
// for the three rail control registers.
// assumes: shared by the register bank, rail_drive_decode and the bench.
package rail_mode_pkg;

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_AUX = 8'h35;
  localparam logic [7:0] IDX_1V2 = 8'h36;
  localparam logic [7:0] IDX_1V0 = 8'h37;

  // reset values
  localparam logic [7:0] AUX_RESET = 8'h0a;
  localparam logic [7:0] R1V2_RESET = 8'h3a;
  localparam logic [7:0] R1V0_RESET = 8'h1a;

  // writable bits of the auxiliary register; upper nibble reads zero
  localparam logic [7:0] AUX_RW_MASK = 8'h0f;

  // field positions
  localparam int MODE_LSB     = 0;
  localparam int MODE_MSB     = 1;
  localparam int EXIT_LSB     = 2;
  localparam int EXIT_MSB     = 3;
  localparam int VSEL_LSB     = 4;
  localparam int VSEL1V2_MSB  = 6;
  localparam int VSEL1V0_MSB  = 5;
  localparam int LP1V2_BIT    = 7;
  localparam int LP1V0_LSB    = 6;
  localparam int LP1V0_MSB    = 7;

  // decode window of the register indices within the bus address
  localparam int IDX_ADDR_LSB = 2;
  localparam int IDX_ADDR_MSB = 9;

  // mode, exit-mode and low-power encodings
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_PWM  = 2'h3;
  localparam logic [1:0] EXIT_NONE = 2'h0;
  localparam logic [1:0] LP_NONE   = 2'h0;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // output trim in half-percent steps of the nominal voltage, signed
  typedef logic signed [4:0] trim_t;
  localparam trim_t TRIM_P5   = 5'h0a;
  localparam trim_t TRIM_P3   = 5'h06;
  localparam trim_t TRIM_P2   = 5'h04;
  localparam trim_t TRIM_P1   = 5'h02;
  localparam trim_t TRIM_ZERO = 5'h00;
  localparam trim_t TRIM_M1   = 5'h1e;
  localparam trim_t TRIM_M2   = 5'h1c;
  localparam trim_t TRIM_M2P5 = 5'h1b;
  localparam trim_t TRIM_M3   = 5'h1a;
  localparam trim_t TRIM_M4   = 5'h18;
  localparam trim_t TRIM_M5   = 5'h16;

  typedef enum {RAIL_1V2, RAIL_1V0} rail_kind_e;

  // what the converter control sees for one regulated rail
  typedef struct packed {
    logic  enabled;
    logic  forced_pwm;
    logic  low_power;
    trim_t trim;
  } rail_drive_s;

  localparam rail_drive_s DRIVE_RESET = '{1'b0, 1'b0, 1'b0, TRIM_ZERO};

endpackage

// file: core/standby_edge_detect.sv
// standby_edge_detect: level and exit edge of the active-low standby request.
// assumes: request input already synchronous to i_clk_sys.
`timescale 1ns/1ns
module standby_edge_detect (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_arst_n,
  // standby request, low means standby
  input  wire logic i_standby_request_n,
  // decoded
  output logic      o_exit_pulse,
  output logic      o_standby_active
);

  logic prev_request_n;
  logic next_prev_request_n;
  logic next_standby_active;

  // previous level starts deasserted so reset never fakes an exit
  always_comb begin
    next_prev_request_n = i_standby_request_n;
    next_standby_active = ~i_standby_request_n;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_request_n   <= 1'b1;
      o_standby_active <= 1'b0;
    end else begin
      prev_request_n   <= next_prev_request_n;
      o_standby_active <= next_standby_active;
    end
  end

  // rising edge of the request marks standby exit
  assign o_exit_pulse = i_standby_request_n & ~prev_request_n;

  property p_exit_one_cycle;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      o_exit_pulse |=> !o_exit_pulse && !o_standby_active;
  endproperty
  a_exit_one_cycle: assert property (p_exit_one_cycle)
    else $error("exit pulse longer than one cycle or standby still active");

endmodule

// file: core/rail_drive_decode.sv
// rail_drive_decode: turns one rail's control byte and the standby level
// into the registered drive word for its converter.
// assumes: control byte comes straight from the register bank.
`timescale 1ns/1ns
module rail_drive_decode #(
  parameter rail_mode_pkg::rail_kind_e KIND = rail_mode_pkg::RAIL_1V2
) (
  // clock and reset
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_arst_n,
  // control byte and standby level
  input  wire logic [7:0]                 i_ctrl,
  input  wire logic                       i_standby_active,
  // converter drive
  output rail_mode_pkg::rail_drive_s      o_drive
);

  rail_mode_pkg::rail_drive_s next_drive;
  logic                       lp_request;
  rail_mode_pkg::trim_t       normal_trim;
  rail_mode_pkg::trim_t       lp_trim;

  function automatic rail_mode_pkg::trim_t trim_1v2(input logic [2:0] sel);
    case (sel)
      3'h0:    trim_1v2 = rail_mode_pkg::TRIM_P3;
      3'h1:    trim_1v2 = rail_mode_pkg::TRIM_P2;
      3'h2:    trim_1v2 = rail_mode_pkg::TRIM_P1;
      3'h3:    trim_1v2 = rail_mode_pkg::TRIM_ZERO;
      3'h4:    trim_1v2 = rail_mode_pkg::TRIM_M1;
      3'h5:    trim_1v2 = rail_mode_pkg::TRIM_M2;
      3'h6:    trim_1v2 = rail_mode_pkg::TRIM_M3;
      default: trim_1v2 = rail_mode_pkg::TRIM_M4;
    endcase
  endfunction

  // 1.05 V, 1 V, 0.975 V, 0.95 V on a 1 V nominal
  function automatic rail_mode_pkg::trim_t trim_1v0(input logic [1:0] sel);
    case (sel)
      2'h0:    trim_1v0 = rail_mode_pkg::TRIM_P5;
      2'h1:    trim_1v0 = rail_mode_pkg::TRIM_ZERO;
      2'h2:    trim_1v0 = rail_mode_pkg::TRIM_M2P5;
      default: trim_1v0 = rail_mode_pkg::TRIM_M5;
    endcase
  endfunction

  function automatic rail_mode_pkg::trim_t lp_1v0(input logic [1:0] sel);
    case (sel)
      2'h1:    lp_1v0 = rail_mode_pkg::TRIM_M4;
      2'h2:    lp_1v0 = rail_mode_pkg::TRIM_M3;
      default: lp_1v0 = rail_mode_pkg::TRIM_M2;
    endcase
  endfunction

  // low-power setpoint only while standby is held, normal select otherwise
  always_comb begin
    if (KIND == rail_mode_pkg::RAIL_1V2) begin
      lp_request  = i_ctrl[rail_mode_pkg::LP1V2_BIT];
      normal_trim = trim_1v2(i_ctrl[rail_mode_pkg::VSEL1V2_MSB:rail_mode_pkg::VSEL_LSB]);
      lp_trim     = rail_mode_pkg::TRIM_M3;
    end else begin
      lp_request  = i_ctrl[rail_mode_pkg::LP1V0_MSB:rail_mode_pkg::LP1V0_LSB]
                    != rail_mode_pkg::LP_NONE;
      normal_trim = trim_1v0(i_ctrl[rail_mode_pkg::VSEL1V0_MSB:rail_mode_pkg::VSEL_LSB]);
      lp_trim     = lp_1v0(i_ctrl[rail_mode_pkg::LP1V0_MSB:rail_mode_pkg::LP1V0_LSB]);
    end
    next_drive.enabled    = i_ctrl[rail_mode_pkg::MODE_MSB:rail_mode_pkg::MODE_LSB]
                            != rail_mode_pkg::MODE_OFF;
    next_drive.forced_pwm = i_ctrl[rail_mode_pkg::MODE_MSB:rail_mode_pkg::MODE_LSB]
                            == rail_mode_pkg::MODE_PWM;
    next_drive.low_power  = i_standby_active & lp_request;
    next_drive.trim       = next_drive.low_power ? lp_trim : normal_trim;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_drive <= rail_mode_pkg::DRIVE_RESET;
    end else begin
      o_drive <= next_drive;
    end
  end

  property p_awake_normal;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      !i_standby_active |=> !o_drive.low_power && o_drive.trim == $past(normal_trim);
  endproperty
  a_awake_normal: assert property (p_awake_normal)
    else $error("low-power setpoint applied while awake");

  property p_mode_decode;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_ctrl[1:0] == rail_mode_pkg::MODE_PWM |=> o_drive.forced_pwm && o_drive.enabled;
  endproperty
  a_mode_decode: assert property (p_mode_decode)
    else $error("forced pwm mode not driven");

  property p_off_decode;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      i_ctrl[1:0] == rail_mode_pkg::MODE_OFF |=> !o_drive.enabled && !o_drive.forced_pwm;
  endproperty
  a_off_decode: assert property (p_off_decode)
    else $error("disabled mode still drives converter");

  if (KIND == rail_mode_pkg::RAIL_1V2) begin : g_chk_1v2
    property p_lp_1v2;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_standby_active && i_ctrl[7] |=> o_drive.low_power
                                          && o_drive.trim == rail_mode_pkg::TRIM_M3;
    endproperty
    a_lp_1v2: assert property (p_lp_1v2)
      else $error("1v2 low-power setpoint not minus three percent");
    property p_vsel_1v2;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
        !i_standby_active && i_ctrl[6:4] == 3'h7 |=> o_drive.trim == rail_mode_pkg::TRIM_M4;
    endproperty
    a_vsel_1v2: assert property (p_vsel_1v2)
      else $error("1v2 top select code not minus four percent");
  end else begin : g_chk_1v0
    property p_lp_1v0;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
        i_standby_active && i_ctrl[7:6] == 2'h1 |=> o_drive.trim == rail_mode_pkg::TRIM_M4;
    endproperty
    a_lp_1v0: assert property (p_lp_1v0)
      else $error("1v0 low-power code 01 not minus four percent");
    property p_vsel_1v0;
      @(posedge i_clk_sys) disable iff (!i_arst_n)
        !i_standby_active && i_ctrl[5:4] == 2'h0 |=> o_drive.trim == rail_mode_pkg::TRIM_P5;
    endproperty
    a_vsel_1v0: assert property (p_vsel_1v0)
      else $error("1v0 select code 00 not plus five percent");
  end

endmodule

// file: core/rail_mode_control_regs.sv
// rail_mode_control_regs: ahb-lite register bank for the auxiliary switch,
// 1.2 V and 1.0 V rails, with standby entry setpoints and exit mode rewrite.
// assumes: one ahb-lite master, single word transfers, standby request
// synchronous to i_clk_sys.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rail_mode_control_regs (
  // clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_arst_n,
  // ahb-lite slave
  input  wire logic                  i_hsel,
  input  wire logic [31:0]           i_haddr,
  input  wire logic [1:0]            i_htrans,
  input  wire logic                  i_hwrite,
  input  wire logic [2:0]            i_hsize,
  input  wire logic [31:0]           i_hwdata,
  input  wire logic                  i_hready,
  output logic                       o_hreadyout,
  output logic                       o_hresp,
  output logic [31:0]                o_hrdata,
  // standby request, active low
  input  wire logic                  i_standby_request_n,
  // rail drives
  output logic                       o_aux_enable,
  output rail_mode_pkg::rail_drive_s o_rail_1v2,
  output rail_mode_pkg::rail_drive_s o_rail_1v0
);

  // register state
  logic [7:0] aux_switch_rail_ctrl;
  logic [7:0] rail_1v2_ctrl;
  logic [7:0] rail_1v0_ctrl;
  logic [7:0] next_aux_switch_rail_ctrl;
  logic [7:0] next_rail_1v2_ctrl;
  logic [7:0] next_rail_1v0_ctrl;

  // bus state
  logic        dp_write;
  logic [7:0]  dp_idx;
  logic        next_dp_write;
  logic [7:0]  next_dp_idx;
  logic [31:0] next_hrdata;
  logic        next_aux_enable;

  // decode helpers
  logic        addr_take;
  logic        addr_hit;
  logic [7:0]  addr_idx;
  logic        wr_aux;
  logic        wr_1v2;
  logic        wr_1v0;
  logic        exit_pulse;
  logic        standby_active;

  // replace the mode field with the exit field unless that field is zero
  function automatic logic [7:0] apply_exit(input logic [7:0] ctrl, input logic exit);
    logic [7:0] res;
    res = ctrl;
    if (exit && ctrl[rail_mode_pkg::EXIT_MSB:rail_mode_pkg::EXIT_LSB]
                != rail_mode_pkg::EXIT_NONE) begin
      res[rail_mode_pkg::MODE_MSB:rail_mode_pkg::MODE_LSB] =
        ctrl[rail_mode_pkg::EXIT_MSB:rail_mode_pkg::EXIT_LSB];
    end
    return res;
  endfunction

  standby_edge_detect u_standby (
    .i_clk_sys           (i_clk_sys),
    .i_arst_n            (i_arst_n),
    .i_standby_request_n (i_standby_request_n),
    .o_exit_pulse        (exit_pulse),
    .o_standby_active    (standby_active)
  );

  // address phase decode; only aligned words in the low index window map
  always_comb begin
    addr_take = i_hsel & i_hready & (i_htrans == rail_mode_pkg::HTRANS_NONSEQ);
    addr_idx  = i_haddr[rail_mode_pkg::IDX_ADDR_MSB:rail_mode_pkg::IDX_ADDR_LSB];
    addr_hit  = (i_haddr[31:rail_mode_pkg::IDX_ADDR_MSB+1] == '0)
                & (i_haddr[rail_mode_pkg::IDX_ADDR_LSB-1:0] == '0);
    next_dp_write = addr_take & i_hwrite & addr_hit;
    next_dp_idx   = addr_take ? addr_idx : dp_idx;
  end

  // data phase write strobes
  always_comb begin
    wr_aux = dp_write & (dp_idx == rail_mode_pkg::IDX_AUX);
    wr_1v2 = dp_write & (dp_idx == rail_mode_pkg::IDX_1V2);
    wr_1v0 = dp_write & (dp_idx == rail_mode_pkg::IDX_1V0);
  end

  // register next values: the write lands first, then the exit rewrite,
  // so an exit in the same cycle as a write still reaches the mode bits
  always_comb begin
    next_aux_switch_rail_ctrl = apply_exit(
      wr_aux ? (i_hwdata[7:0] & rail_mode_pkg::AUX_RW_MASK) : aux_switch_rail_ctrl,
      exit_pulse);
    next_rail_1v2_ctrl = apply_exit(wr_1v2 ? i_hwdata[7:0] : rail_1v2_ctrl,
                                    exit_pulse);
    next_rail_1v0_ctrl = apply_exit(wr_1v0 ? i_hwdata[7:0] : rail_1v0_ctrl,
                                    exit_pulse);
    next_aux_enable = next_aux_switch_rail_ctrl[rail_mode_pkg::MODE_MSB:rail_mode_pkg::MODE_LSB]
                      != rail_mode_pkg::MODE_OFF;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aux_switch_rail_ctrl <= rail_mode_pkg::AUX_RESET;
      rail_1v2_ctrl        <= rail_mode_pkg::R1V2_RESET;
      rail_1v0_ctrl        <= rail_mode_pkg::R1V0_RESET;
      o_aux_enable         <= 1'b0;
    end else begin
      aux_switch_rail_ctrl <= next_aux_switch_rail_ctrl;
      rail_1v2_ctrl        <= next_rail_1v2_ctrl;
      rail_1v0_ctrl        <= next_rail_1v0_ctrl;
      o_aux_enable         <= next_aux_enable;
    end
  end

  // read data captured at the end of the address phase from next values,
  // so a write just before a read is seen; unmapped reads give zero
  always_comb begin
    next_hrdata = '0;
    if (addr_take & ~i_hwrite & addr_hit) begin
      case (addr_idx)
        rail_mode_pkg::IDX_AUX: next_hrdata[7:0] = next_aux_switch_rail_ctrl;
        rail_mode_pkg::IDX_1V2: next_hrdata[7:0] = next_rail_1v2_ctrl;
        rail_mode_pkg::IDX_1V0: next_hrdata[7:0] = next_rail_1v0_ctrl;
        default:                next_hrdata      = '0;
      endcase
    end
  end

  // zero wait state slave, always okay
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dp_write    <= 1'b0;
      dp_idx      <= 8'h00;
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= rail_mode_pkg::HRESP_OKAY;
    end else begin
      dp_write    <= next_dp_write;
      dp_idx      <= next_dp_idx;
      o_hrdata    <= next_hrdata;
      o_hreadyout <= 1'b1;
      o_hresp     <= rail_mode_pkg::HRESP_OKAY;
    end
  end

  // regulated rails; aux switch only needs its enable
  rail_drive_decode #(
    .KIND (rail_mode_pkg::RAIL_1V2)
  ) u_drive_1v2 (
    .i_clk_sys        (i_clk_sys),
    .i_arst_n         (i_arst_n),
    .i_ctrl           (rail_1v2_ctrl),
    .i_standby_active (standby_active),
    .o_drive          (o_rail_1v2)
  );

  rail_drive_decode #(
    .KIND (rail_mode_pkg::RAIL_1V0)
  ) u_drive_1v0 (
    .i_clk_sys        (i_clk_sys),
    .i_arst_n         (i_arst_n),
    .i_ctrl           (rail_1v0_ctrl),
    .i_standby_active (standby_active),
    .o_drive          (o_rail_1v0)
  );

  property p_aux_reserved_zero;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      wr_aux |=> aux_switch_rail_ctrl[7:4] == 4'h0;
  endproperty
  a_aux_reserved_zero: assert property (p_aux_reserved_zero)
    else $error("aux reserved nibble took a write");

  property p_exit_copy_1v2;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_1v2 && rail_1v2_ctrl[3:2] != 2'h0
        |=> rail_1v2_ctrl[1:0] == $past(rail_1v2_ctrl[3:2]);
  endproperty
  a_exit_copy_1v2: assert property (p_exit_copy_1v2)
    else $error("1v2 mode not rewritten on standby exit");

  property p_exit_copy_aux;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_aux && aux_switch_rail_ctrl[3:2] != 2'h0
        |=> aux_switch_rail_ctrl[1:0] == $past(aux_switch_rail_ctrl[3:2])
            && o_aux_enable;
  endproperty
  a_exit_copy_aux: assert property (p_exit_copy_aux)
    else $error("aux mode not rewritten or not enabled after exit");

  property p_exit_hold_1v0;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_1v0 && rail_1v0_ctrl[3:2] == 2'h0 |=> $stable(rail_1v0_ctrl);
  endproperty
  a_exit_hold_1v0: assert property (p_exit_hold_1v0)
    else $error("1v0 changed on exit with exit field zero");

  property p_aux_enable;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      aux_switch_rail_ctrl[1:0] == 2'h0 && !wr_aux && !exit_pulse |=> !o_aux_enable;
  endproperty
  a_aux_enable: assert property (p_aux_enable)
    else $error("aux rail enabled with mode zero");

  property p_write_1v2;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      wr_1v2 && !exit_pulse |=> rail_1v2_ctrl == $past(i_hwdata[7:0]);
  endproperty
  a_write_1v2: assert property (p_write_1v2)
    else $error("1v2 register did not take the full write");

  property p_write_1v0;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      wr_1v0 && !exit_pulse |=> rail_1v0_ctrl == $past(i_hwdata[7:0]);
  endproperty
  a_write_1v0: assert property (p_write_1v0)
    else $error("1v0 register did not take the full write");

  property p_read_1v0;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      addr_take && !i_hwrite && i_haddr == 32'h0000_00dc && !dp_write && !exit_pulse
        |=> o_hrdata == {24'h00_0000, $past(rail_1v0_ctrl)};
  endproperty
  a_read_1v0: assert property (p_read_1v0)
    else $error("1v0 read data wrong");

  property p_exit_copy_1v0;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_1v0 && rail_1v0_ctrl[3:2] != 2'h0
        |=> rail_1v0_ctrl[1:0] == $past(rail_1v0_ctrl[3:2]);
  endproperty
  a_exit_copy_1v0: assert property (p_exit_copy_1v0)
    else $error("1v0 mode not rewritten on standby exit");

  property p_exit_hold_1v2;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_1v2 && rail_1v2_ctrl[3:2] == 2'h0 |=> $stable(rail_1v2_ctrl);
  endproperty
  a_exit_hold_1v2: assert property (p_exit_hold_1v2)
    else $error("1v2 changed on exit with exit field zero");

  property p_exit_hold_aux;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      exit_pulse && !wr_aux && aux_switch_rail_ctrl[3:2] == 2'h0
        |=> $stable(aux_switch_rail_ctrl);
  endproperty
  a_exit_hold_aux: assert property (p_exit_hold_aux)
    else $error("aux changed on exit with exit field zero");

  property p_write_aux;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      wr_aux && !exit_pulse
        |=> aux_switch_rail_ctrl == ($past(i_hwdata[7:0]) & rail_mode_pkg::AUX_RW_MASK);
  endproperty
  a_write_aux: assert property (p_write_aux)
    else $error("aux register did not take the masked write");

  property p_read_aux;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      addr_take && !i_hwrite && i_haddr == 32'h0000_00d4 && !dp_write && !exit_pulse
        |=> o_hrdata == {24'h00_0000, $past(aux_switch_rail_ctrl)};
  endproperty
  a_read_aux: assert property (p_read_aux)
    else $error("aux read data wrong");

  property p_read_1v2;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      addr_take && !i_hwrite && i_haddr == 32'h0000_00d8 && !dp_write && !exit_pulse
        |=> o_hrdata == {24'h00_0000, $past(rail_1v2_ctrl)};
  endproperty
  a_read_1v2: assert property (p_read_1v2)
    else $error("1v2 read data wrong");

  property p_unmapped_read;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      addr_take && !i_hwrite && !addr_hit |=> o_hrdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read returned nonzero data");

  property p_aux_enable_on;
    @(posedge i_clk_sys) disable iff (!i_arst_n)
      aux_switch_rail_ctrl[1:0] != 2'h0 && !wr_aux && !exit_pulse |=> o_aux_enable;
  endproperty
  a_aux_enable_on: assert property (p_aux_enable_on)
    else $error("aux rail disabled with nonzero mode");

endmodule

// file: verification/rail_mode_control_regs_tb.sv
// rail_mode_control_regs_tb: self-checking bench for the rail register bank.
// assumes: the bench is the only ahb-lite master and drives standby itself;
// hready is looped back from the slave's hreadyout.
`timescale 1ns/1ns
module rail_mode_control_regs_tb;
  // design ports
  logic                       i_clk_sys;
  logic                       i_arst_n;
  logic                       i_hsel;
  logic [31:0]                i_haddr;
  logic [1:0]                 i_htrans;
  logic                       i_hwrite;
  logic [2:0]                 i_hsize;
  logic [31:0]                i_hwdata;
  logic                       i_standby_request_n;
  logic                       o_hreadyout;
  logic                       o_hresp;
  logic [31:0]                o_hrdata;
  logic                       o_aux_enable;
  rail_mode_pkg::rail_drive_s o_rail_1v2;
  rail_mode_pkg::rail_drive_s o_rail_1v0;
  // bench state
  int                         fail_count;
  int                         cmp_count;
  int                         cycles;
  logic [7:0]                 shadow [3];
  logic [31:0]                rd;
  logic [7:0]                 wv;
  int                         ri;

  localparam logic [7:0] REG_IDX [3] = '{rail_mode_pkg::IDX_AUX, rail_mode_pkg::IDX_1V2,
                                         rail_mode_pkg::IDX_1V0};
  localparam rail_mode_pkg::trim_t VSEL_1V0 [4] = '{rail_mode_pkg::TRIM_P5,
    rail_mode_pkg::TRIM_ZERO, rail_mode_pkg::TRIM_M2P5, rail_mode_pkg::TRIM_M5};
  localparam rail_mode_pkg::trim_t LP_1V0 [4] = '{rail_mode_pkg::TRIM_ZERO,
    rail_mode_pkg::TRIM_M4, rail_mode_pkg::TRIM_M3, rail_mode_pkg::TRIM_M2};

  rail_mode_control_regs dut (
    .i_clk_sys           (i_clk_sys),
    .i_arst_n            (i_arst_n),
    .i_hsel              (i_hsel),
    .i_haddr             (i_haddr),
    .i_htrans            (i_htrans),
    .i_hwrite            (i_hwrite),
    .i_hsize             (i_hsize),
    .i_hwdata            (i_hwdata),
    .i_hready            (o_hreadyout),
    .o_hreadyout         (o_hreadyout),
    .o_hresp             (o_hresp),
    .o_hrdata            (o_hrdata),
    .i_standby_request_n (i_standby_request_n),
    .o_aux_enable        (o_aux_enable),
    .o_rail_1v2          (o_rail_1v2),
    .o_rail_1v0          (o_rail_1v0)
  );

  // 125 MHz system clock
  always #4 i_clk_sys = ~i_clk_sys;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  function automatic logic [31:0] addr(input logic [7:0] idx);
    return {22'h00_0000, idx, 2'h0};
  endfunction

  // expected drive word; is_1v0 picks the 1.0 V field layout
  function automatic rail_mode_pkg::rail_drive_s exp_drive(input logic [7:0] r,
                                                           input logic sb,
                                                           input logic is_1v0);
    rail_mode_pkg::rail_drive_s e;
    logic                       lp;
    lp = sb & (is_1v0 ? (r[7:6] != rail_mode_pkg::LP_NONE) : r[7]);
    e.enabled = (r[1:0] != rail_mode_pkg::MODE_OFF);
    e.forced_pwm = (r[1:0] == rail_mode_pkg::MODE_PWM);
    e.low_power = lp;
    if (is_1v0) begin
      e.trim = lp ? LP_1V0[r[7:6]] : VSEL_1V0[r[5:4]];
    end else begin
      e.trim = lp ? rail_mode_pkg::TRIM_M3 : rail_mode_pkg::trim_t'(6 - 2 * int'(r[6:4]));
    end
    return e;
  endfunction

  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus_xfer(input logic [31:0] a, input logic wr, input logic [7:0] d,
                          output logic [31:0] q);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= rail_mode_pkg::HTRANS_NONSEQ;
    i_hwrite <= wr;
    @(posedge i_clk_sys);
    while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
    i_htrans <= 2'h0;
    i_hsel <= 1'b0;
    i_hwdata <= {24'h00_0000, d};
    @(posedge i_clk_sys);
    while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
    q = o_hrdata;
    check("hresp", {31'h0000_0000, o_hresp}, {31'h0000_0000, rail_mode_pkg::HRESP_OKAY});
  endtask

  task automatic check_regs();
    logic [31:0] q;
    for (int k = 0; k < 3; k++) begin
      bus_xfer(addr(REG_IDX[k]), 1'b0, 8'h00, q);
      check("register read", q, {24'h00_0000, shadow[k]});
    end
  endtask

  task automatic check_drive(input logic sb);
    check("aux enable", {31'h0000_0000, o_aux_enable},
          {31'h0000_0000, shadow[0][1:0] != rail_mode_pkg::MODE_OFF});
    check("rail 1v2 drive", {24'h00_0000, o_rail_1v2},
          {24'h00_0000, exp_drive(shadow[1], sb, 1'b0)});
    check("rail 1v0 drive", {24'h00_0000, o_rail_1v0},
          {24'h00_0000, exp_drive(shadow[2], sb, 1'b1)});
  endtask

  // write through the bus and keep the bench copy in step
  task automatic reg_write(input int k, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(addr(REG_IDX[k]), 1'b1, d, q);
    shadow[k] = (k == 0) ? (d & rail_mode_pkg::AUX_RW_MASK) : d;
  endtask

  // enter standby, check setpoints, leave and check the mode rewrite
  task automatic standby_cycle();
    i_standby_request_n <= 1'b0;
    wait_clk(4);
    check_drive(1'b1);
    i_standby_request_n <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (shadow[k][3:2] != rail_mode_pkg::EXIT_NONE) shadow[k][1:0] = shadow[k][3:2];
    end
    wait_clk(4);
    check_drive(1'b0);
    check_regs();
  endtask

  initial begin
    i_clk_sys = 1'b0;
    i_arst_n = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h0000_0000;
    i_htrans = 2'h0;
    i_hwrite = 1'b0;
    i_hsize = 3'h2;
    i_hwdata = 32'h0000_0000;
    i_standby_request_n = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    cycles = 0;
    shadow[0] = rail_mode_pkg::AUX_RESET;
    shadow[1] = rail_mode_pkg::R1V2_RESET;
    shadow[2] = rail_mode_pkg::R1V0_RESET;
    void'($urandom(60286));
    wait_clk(6);
    i_arst_n <= 1'b1;
    wait_clk(2);
    // reset values and the drive words decoded from them
    check_regs();
    check_drive(1'b0);
    // reserved nibble, unmapped and misaligned places
    reg_write(0, 8'hff);
    bus_xfer(32'h0000_00e0, 1'b1, 8'h55, rd);
    bus_xfer(32'h0000_00e0, 1'b0, 8'h00, rd);
    check("unmapped read", rd, 32'h0000_0000);
    bus_xfer(32'h0000_00d5, 1'b0, 8'h00, rd);
    check("misaligned read", rd, 32'h0000_0000);
    check_regs();
    // exit field zero on 1v2 while the others rewrite their mode
    reg_write(0, 8'h04);
    reg_write(1, 8'h93);
    reg_write(2, 8'hcd);
    standby_cycle();
    // 1v2 top select code awake, 1v0 low-power code 01 and exit field zero
    reg_write(1, 8'h7b);
    reg_write(2, 8'h61);
    standby_cycle();
    // random writes, with standby excursions among them
    repeat (40) begin
      ri = $urandom_range(2, 0);
      wv = 8'($urandom);
      reg_write(ri, wv);
      if ($urandom_range(2, 0) == 0) begin
        standby_cycle();
      end else begin
        wait_clk(3);
        check_drive(1'b0);
        check_regs();
      end
    end
    test_done();
  end
endmodule
